// ---- verilog/drl_pkg.sv ----
// package: ddr read latency table, opcodes, offsets and reset values
package drl_pkg;

  // ----------------------------------------------------------------
  // ddr read opcodes (3-byte / 4-byte address)
  // ----------------------------------------------------------------
  localparam logic [7:0] DRL_OP_FAST3 = 8'h0D;
  localparam logic [7:0] DRL_OP_FAST4 = 8'h0E;
  localparam logic [7:0] DRL_OP_DUAL3 = 8'hBD;
  localparam logic [7:0] DRL_OP_DUAL4 = 8'hBE;
  localparam logic [7:0] DRL_OP_QUAD3 = 8'hED;
  localparam logic [7:0] DRL_OP_QUAD4 = 8'hEE;

  // ----------------------------------------------------------------
  // command kinds, index the mode/dummy pairs of a table row
  // ----------------------------------------------------------------
  localparam logic [1:0] DRL_KIND_FAST = 2'h0;
  localparam logic [1:0] DRL_KIND_DUAL = 2'h1;
  localparam logic [1:0] DRL_KIND_QUAD = 2'h2;
  localparam logic [1:0] DRL_KIND_NONE = 2'h3;

  // ----------------------------------------------------------------
  // latency table layout
  // ----------------------------------------------------------------
  localparam int         DRL_TBL_LEN   = 44;
  localparam int         DRL_ROWS      = 4;
  localparam logic [5:0] DRL_ROW_FIRST = 6'h0C;
  localparam logic [5:0] DRL_ROW_LEN   = 6'h08;
  localparam logic [5:0] DRL_OFS_FREQ  = 6'h00;
  localparam logic [5:0] DRL_OFS_CODE  = 6'h01;
  localparam logic [5:0] DRL_OFS_MODE  = 6'h02;
  localparam logic [5:0] DRL_OFS_DUMMY = 6'h03;

  // published parameter bytes; row order: codes 11b, 00b, 01b, 10b
  localparam logic [7:0] DRL_TBL [DRL_TBL_LEN] = '{
    8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
    DRL_OP_FAST3, DRL_OP_FAST4, DRL_OP_DUAL3, DRL_OP_DUAL4,
    DRL_OP_QUAD3, DRL_OP_QUAD4,
    8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03,
    8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06,
    8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
    8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08
  };

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] DRL_CYC_RST  = 4'h0;
  localparam logic [4:0] DRL_CNT_RST  = 5'h00;
  localparam logic [7:0] DRL_BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    DRL_ST_IDLE,
    DRL_ST_WAIT,
    DRL_ST_DATA
  } drl_state_t;

endpackage : drl_pkg

// ---- verilog/drl_sync.sv ----
// three-stage synchroniser with agreement filter for one pin
module drl_sync (
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  input  wire logic rst_val_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // stages carry pin xor its idle level: the constant all-zero reset
  // then reads back as idle, so no false select follows reset
  // s1_q is read only by s2_q
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in ^ rst_val_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level_out = lvl_q ^ rst_val_in;

endmodule : drl_sync

// ---- verilog/drl_top.sv ----
// ddr read latency selector: mode/dummy counts, wait counter, table
//
// Function
// R1 - code 11b to 50 MHz: fast, dual 0 mode 4 dummy; quad 1 mode 3
// R2 - code 00b to 66 MHz: fast 0/5, dual 0/6, quad 1/6 mode/dummy
// R3 - code 01b to 66 MHz: fast 0/6, dual 0/7, quad 1/7 mode/dummy
// R4 - code 10b to 66 MHz: fast 0/7, dual 0/8, quad 1/8 mode/dummy
// R5 - table readable as query parameter with identifier 9Ah
// R6 - ddr opcodes: fast 0Dh/0Eh, dual BDh/BEh, quad EDh/EEh
// R7 - host picks a fitting code and counts the same cycles
module drl_top
  import drl_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic [1:0] lat_code_in,
  input  wire logic [5:0] tbl_addr_in,
  output logic            cmd_ddr_out,
  output logic [3:0]      mode_cyc_out,
  output logic [3:0]      dummy_cyc_out,
  output logic [7:0]      freq_limit_out,
  output logic            wait_busy_out,
  output logic            data_phase_out,
  output logic [7:0]      tbl_data_out
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] op_kind(input logic [7:0] op);
    logic [1:0] k;
    k = DRL_KIND_NONE;
    if (op == DRL_OP_FAST3 || op == DRL_OP_FAST4) k = DRL_KIND_FAST; // R6
    if (op == DRL_OP_DUAL3 || op == DRL_OP_DUAL4) k = DRL_KIND_DUAL; // R6
    if (op == DRL_OP_QUAD3 || op == DRL_OP_QUAD4) k = DRL_KIND_QUAD; // R6
    return k;
  endfunction : op_kind

  // row start holding the given latency code
  function automatic logic [5:0] row_base(input logic [1:0] code);
    logic [5:0] b;
    logic [5:0] a;
    b = DRL_ROW_FIRST;
    for (int r = 0; r < DRL_ROWS; r++) begin
      a = DRL_ROW_FIRST + 6'(r) * DRL_ROW_LEN;
      if (DRL_TBL[a + DRL_OFS_CODE] == {6'h00, code}) b = a;
    end
    return b;
  endfunction : row_base

  function automatic logic [7:0] tbl_byte(input logic [5:0] idx);
    logic [7:0] v;
    v = DRL_BYTE_RST;
    if (int'(idx) < DRL_TBL_LEN) v = DRL_TBL[idx];
    return v;
  endfunction : tbl_byte

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sck_lvl;
  logic cs_n_lvl;
  logic sck_prev_q;
  logic sck_rise;

  drl_sync u_sync_sck (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .rst_val_in (1'b0),
    .pin_in     (sck_in),
    .level_out  (sck_lvl)
  );

  drl_sync u_sync_cs (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .rst_val_in (1'b1),
    .pin_in     (cs_n_in),
    .level_out  (cs_n_lvl)
  );

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_lvl;
    end
  end

  assign sck_rise = sck_lvl && !sck_prev_q;

  // ----------------------------------------------------------------
  // latency selection
  // ----------------------------------------------------------------
  logic [1:0] kind_d;
  logic [5:0] base_d;
  logic [5:0] sel_d;
  logic [3:0] mode_d;
  logic [3:0] dummy_d;

  always_comb begin
    kind_d  = op_kind(opcode_in);
    base_d  = row_base(lat_code_in);
    sel_d   = base_d + {3'h0, kind_d, 1'b0};
    mode_d  = DRL_TBL[sel_d + DRL_OFS_MODE][3:0];   // R1 R2 R3 R4
    dummy_d = DRL_TBL[sel_d + DRL_OFS_DUMMY][3:0];  // R1 R2 R3 R4
    if (kind_d == DRL_KIND_NONE) begin
      mode_d  = DRL_CYC_RST;
      dummy_d = DRL_CYC_RST;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ddr_out    <= 1'b0;
      mode_cyc_out   <= DRL_CYC_RST;
      dummy_cyc_out  <= DRL_CYC_RST;
      freq_limit_out <= DRL_BYTE_RST;
    end else if (cmd_valid_in) begin
      cmd_ddr_out    <= (kind_d != DRL_KIND_NONE);
      mode_cyc_out   <= mode_d;
      dummy_cyc_out  <= dummy_d;
      freq_limit_out <= DRL_TBL[base_d + DRL_OFS_FREQ];
    end
  end

  // ----------------------------------------------------------------
  // wait counter over synchronised sck rising edges
  // ----------------------------------------------------------------
  // sck must be slow enough for three-stage sampling; ddr edges of
  // the data phase are not tracked here, only latency cycles
  drl_state_t state_q;
  logic [4:0] cnt_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= DRL_ST_IDLE;
      cnt_q   <= DRL_CNT_RST;
    end else if (cs_n_lvl) begin
      state_q <= DRL_ST_IDLE;
      cnt_q   <= DRL_CNT_RST;
    end else begin
      unique case (state_q)
        DRL_ST_IDLE: begin
          if (cmd_valid_in && kind_d != DRL_KIND_NONE) begin
            state_q <= DRL_ST_WAIT;
            cnt_q   <= {1'b0, mode_d} + {1'b0, dummy_d};
          end
        end
        DRL_ST_WAIT: begin
          if (sck_rise) begin
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) state_q <= DRL_ST_DATA;
          end
        end
        DRL_ST_DATA: begin
          cnt_q <= DRL_CNT_RST;
        end
        default: begin
          state_q <= DRL_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_busy_out  <= 1'b0;
      data_phase_out <= 1'b0;
    end else begin
      wait_busy_out  <= (state_q == DRL_ST_WAIT) && !cs_n_lvl;
      data_phase_out <= (state_q == DRL_ST_DATA) && !cs_n_lvl;
    end
  end

  // ----------------------------------------------------------------
  // query parameter readout
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tbl_data_out <= DRL_BYTE_RST;
    end else begin
      tbl_data_out <= tbl_byte(tbl_addr_in); // R5
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_code11_counts: assert property ( // R1
    cmd_valid_in && lat_code_in == 2'h3 && kind_d != DRL_KIND_NONE
    |=> (freq_limit_out == 8'h32) && (dummy_cyc_out ==
        (($past(kind_d) == DRL_KIND_QUAD) ? 4'h3 : 4'h4)))
    else $error("code 11b counts wrong");

  a_code00_counts: assert property ( // R2
    cmd_valid_in && lat_code_in == 2'h0 && kind_d == DRL_KIND_DUAL
    |=> mode_cyc_out == 4'h0 && dummy_cyc_out == 4'h6)
    else $error("code 00b dual counts wrong");

  a_code01_counts: assert property ( // R3
    cmd_valid_in && lat_code_in == 2'h1 && kind_d == DRL_KIND_QUAD
    |=> mode_cyc_out == 4'h1 && dummy_cyc_out == 4'h7)
    else $error("code 01b quad counts wrong");

  a_code10_counts: assert property ( // R4
    cmd_valid_in && lat_code_in == 2'h2 && kind_d == DRL_KIND_FAST
    |=> mode_cyc_out == 4'h0 && dummy_cyc_out == 4'h7
        && freq_limit_out == 8'h42)
    else $error("code 10b fast counts wrong");

  a_param_id_read: assert property ( // R5
    tbl_addr_in == 6'h00 |=> tbl_data_out == 8'h9A)
    else $error("parameter identifier wrong");

  a_opcode_decode: assert property ( // R6
    cmd_valid_in |=> cmd_ddr_out == ($past(opcode_in) inside
      {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE}))
    else $error("ddr opcode decode wrong");

  a_wait_load: assert property (
    state_q == DRL_ST_IDLE && !cs_n_lvl && cmd_valid_in
    && kind_d != DRL_KIND_NONE
    |=> state_q == DRL_ST_WAIT && cnt_q == mode_cyc_out + dummy_cyc_out)
    else $error("wait counter not loaded");

  a_wait_done: assert property (
    state_q == DRL_ST_WAIT && sck_rise && cnt_q == 5'h01 && !cs_n_lvl
    |=> state_q == DRL_ST_DATA ##1 data_phase_out || cs_n_lvl)
    else $error("data phase not reached");

  c_quad_read:  cover property (cmd_valid_in && kind_d == DRL_KIND_QUAD);
  c_data_phase: cover property (state_q == DRL_ST_WAIT ##[1:400]
                                state_q == DRL_ST_DATA);
  c_abort_cs:   cover property (state_q == DRL_ST_WAIT && cs_n_lvl);

endmodule : drl_top

// ---- tb/drl_host_model.sv ----
// host controller model: chip select frames and serial clock bursts
module drl_host_model (
  input  wire logic       frame_in,
  input  wire logic       burst_in,
  input  wire logic [4:0] n_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    busy_out = 1'b0;
  end

  always @(frame_in) #30 cs_n_out = ~frame_in;

  // sck idles low outside bursts; one rise per latency cycle
  always @(posedge burst_in) begin
    busy_out = 1'b1;
    // keeps sck edges off the system clock edges
    #5;
    repeat (n_in) begin
      #80 sck_out = 1'b1;
      #80 sck_out = 1'b0;
    end
    busy_out = 1'b0;
  end
endmodule : drl_host_model

// ---- tb/tb_drl_top.sv ----
// testbench for the ddr read latency selector
module tb_drl_top
  import drl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] OPS [6] = '{DRL_OP_FAST3, DRL_OP_FAST4,
    DRL_OP_DUAL3, DRL_OP_DUAL4, DRL_OP_QUAD3, DRL_OP_QUAD4};
  localparam logic [7:0] HDR [6] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46,
    8'h43};

  logic       sys_clk_in   = 1'b0;
  logic       nrst_in      = 1'b0;
  logic       cmd_valid_in = 1'b0;
  logic [7:0] opcode_in    = 8'h00;
  logic [1:0] lat_code_in  = 2'h0;
  logic [5:0] tbl_addr_in  = 6'h00;
  logic       frame        = 1'b0;
  logic       burst        = 1'b0;
  logic [4:0] n_sck        = 5'h00;
  logic       sck, cs_n, mbusy, cmd_ddr, wbusy, dphase;
  logic [3:0] mode_cyc, dummy_cyc;
  logic [7:0] freq, tdata;
  int         errors = 0;
  int         checks = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  drl_host_model drl_host_model_inst (.frame_in(frame), .burst_in(burst),
    .n_in(n_sck), .sck_out(sck), .cs_n_out(cs_n), .busy_out(mbusy));

  drl_top drl_top_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .sck_in(sck), .cs_n_in(cs_n), .cmd_valid_in(cmd_valid_in),
    .opcode_in(opcode_in), .lat_code_in(lat_code_in),
    .tbl_addr_in(tbl_addr_in), .cmd_ddr_out(cmd_ddr),
    .mode_cyc_out(mode_cyc), .dummy_cyc_out(dummy_cyc),
    .freq_limit_out(freq), .wait_busy_out(wbusy),
    .data_phase_out(dphase), .tbl_data_out(tdata));

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_dum(logic [1:0] c, int k);
    if (k == 3) return 8'h00;
    if (c == 2'h3) return (k == 2) ? 8'h03 : 8'h04;
    return 8'(c + 5 + (k != 0));
  endfunction : exp_dum

  function automatic logic [7:0] exp_tbl(int a);
    int o;
    logic [1:0] c;
    o = (a - 12) % 8;
    c = 2'((a - 12) / 8 + 3);
    if (a < 6) return HDR[a];
    if (a < 12) return OPS[a - 6];
    if (a >= 44) return 8'h00;
    if (o == 0) return (c == 2'h3) ? 8'h32 : 8'h42;
    if (o == 1) return {6'h00, c};
    if (o % 2 == 0) return (o == 6) ? 8'h01 : 8'h00;
    return exp_dum(c, (o - 3) / 2);
  endfunction : exp_tbl

  task automatic chk(logic [7:0] seen, logic [7:0] exp, string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_table();
    for (int a = 0; a < 48; a++) begin
      @(posedge sys_clk_in) tbl_addr_in <= 6'(a);
      @(posedge sys_clk_in) #1;
      chk(tdata, exp_tbl(a), "table byte");
    end
  endtask : test_table

  // back to back takes; kind 3 is a non-ddr opcode
  task automatic test_select();
    logic [1:0] c, pc;
    int k, pk;
    for (int i = 0; i < 26; i++) begin
      c = (i < 24) ? 2'(i / 6) : 2'h1;
      k = (i < 24) ? (i % 6) / 2 : 3;
      @(posedge sys_clk_in);
      cmd_valid_in <= (i < 25);
      opcode_in <= (i < 24) ? OPS[i % 6] : 8'h0B;
      lat_code_in <= c;
      if (i > 0) begin
        #1;
        chk(8'(cmd_ddr), 8'(pk < 3), "ddr flag");
        chk(8'(mode_cyc), 8'(pk == 2), "mode");
        chk(8'(dummy_cyc), exp_dum(pc, pk), "dummy");
        chk(freq, (pc == 2'h3) ? 8'h32 : 8'h42, "freq");
      end
      pc = c;
      pk = k;
    end
  endtask : test_select

  task automatic sck_burst(int m);
    @(posedge sys_clk_in);
    n_sck <= 5'(m);
    burst <= 1'b1;
    @(posedge sys_clk_in) burst <= 1'b0;
    for (int t = 0; t < 200 && mbusy !== 1'b0; t++) @(posedge sys_clk_in);
    chk(8'(mbusy), 8'h00, "burst ended");
    repeat (8) @(posedge sys_clk_in);
    #1;
  endtask : sck_burst

  task automatic run_wait(int oi, logic [1:0] c);
    int cnt;
    cnt = (oi / 2 == 2) + int'(exp_dum(c, oi / 2));
    @(posedge sys_clk_in) frame <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    opcode_in <= OPS[oi];
    lat_code_in <= c;
    @(posedge sys_clk_in) cmd_valid_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(8'(wbusy), 8'h01, "busy after take");
    sck_burst(cnt - 1);
    chk(8'(wbusy), 8'h01, "busy one short");
    chk(8'(dphase), 8'h00, "data too early");
    sck_burst(1);
    chk(8'(dphase), 8'h01, "data phase");
    chk(8'(wbusy), 8'h00, "busy cleared");
    // a new command inside the frame must not restart the count
    @(posedge sys_clk_in) cmd_valid_in <= 1'b1;
    @(posedge sys_clk_in) cmd_valid_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(8'(dphase), 8'h01, "refused in data");
    @(posedge sys_clk_in) frame <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    #1;
    chk(8'(dphase), 8'h00, "data ends on cs");
  endtask : run_wait

  // frame dropped mid-wait, then a reset applied in mid-wait
  task automatic test_abort();
    @(posedge sys_clk_in) frame <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    opcode_in    <= DRL_OP_QUAD4;
    lat_code_in  <= 2'h0;
    @(posedge sys_clk_in) cmd_valid_in <= 1'b0;
    sck_burst(3);
    chk(8'(wbusy), 8'h01, "busy before abort");
    @(posedge sys_clk_in) frame <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    #1;
    chk({6'h00, wbusy, dphase}, 8'h00, "abort on cs");
    @(posedge sys_clk_in) frame <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    @(posedge sys_clk_in) cmd_valid_in <= 1'b0;
    sck_burst(2);
    @(posedge sys_clk_in) nrst_in <= 1'b0;
    frame <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in) #1;
    chk({cmd_ddr, wbusy, dphase, mode_cyc}, 8'h00, "mid reset");
    chk({4'h0, dummy_cyc}, 8'h00, "mid reset dummy");
    chk(freq, 8'h00, "mid reset freq");
    repeat (4) @(posedge sys_clk_in);
  endtask : test_abort

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in) #1;
    chk({cmd_ddr, wbusy, dphase, mode_cyc}, 8'h00, "reset");
    repeat (4) @(posedge sys_clk_in);
    test_table();
    test_select();
    test_abort();
    run_wait(0, 2'h3);
    run_wait(3, 2'h1);
    run_wait(4, 2'h2);
    run_wait(5, 2'h3);
    finish_test();
  end

  // whole run is near 620 cycles; this allows ample margin
  initial begin
    #200000;
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    finish_test();
  end
endmodule : tb_drl_top
